//--- rtl/ast_uart.sv
// Asynchronous serial transceiver: transmitter, receiver, baud generator.
// Assumes rx_pin is synchronous to clk_sys; software side is plain ports.
// Functional notes
// - Idle line high, start is falling edge
// - Start, data LSB first, parity, stop
// - Start valid on two of three zeros
// - Seven, eight or nine bit modes
// - Transmit seven, eight or nine bits LSB first
// - Independent double-buffered transmit and receive
// - Send only when enabled; write sets flag
// - One odd or even parity bit
// - One stop bit then line high
// - Empty interrupt after stop bit
// - Receive only while receive enabled
// - Receive data shifted in LSB first
// - Full character sets receive-full flag
// - Check received parity against setting
// - Bad stop flags framing; bad start is dropped
// - Load while full flags overrun
// - Errors set flags, raise interrupt, sticky
// - Uncleared error re-raises on next byte
// - Reading receive data clears full flag
// - Baud generator selected by three bits
`timescale 1ns/10ps
module ast_uart
  import ast_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ast_cfg_t cfg,
  input wire logic [8:0] tx_data_reg,
  input wire logic tx_write,
  input wire logic tx_irq_en,
  output logic tx_buffer_flag,
  output logic tx_empty_irq,
  output logic tx_pin,
  input wire logic rx_pin,
  input wire logic err_irq_en,
  input wire ast_err_t err_clear,
  output logic [8:0] rx_data_reg,
  input wire logic rx_read,
  output logic rx_full_flag,
  output ast_err_t err_flags,
  output logic rx_error_irq
);
  // Transmit and receive sequencer states
  typedef enum logic [2:0] {
    AST_IDLE, AST_START, AST_DATA, AST_PAR, AST_STOP
  } ast_state_t;

  // Sequencer and divider state in one packed struct
  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    ast_state_t tx_st;
    logic [3:0] tx_tick;
    logic [3:0] tx_bit;
    logic [8:0] tx_hold;
    logic tx_full;
    logic [8:0] tx_shift;
    logic tx_par; // Parity of the word in the shifter, fixed at load
    logic tx_line;
    logic tx_irq;
    ast_state_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [2:0] smp;
    logic [8:0] rx_shift;
    logic rx_par;
    logic rx_frame_bad;
    logic rx_prev;
    logic err_irq;
  } ast_regs_t;

  ast_regs_t r;
  ast_regs_t next_r;

  // FIFO between the receive shifter and the receive data register
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic [8:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_par_bad;
  logic fifo_frm_bad;

  // Output registers outside the struct kept separate for clarity of loads
  logic [8:0] rx_data_q;
  logic rx_full_q;
  ast_err_t err_q;
  logic err_pulse;

  // Oversample tick, divider count chosen by baud select
  logic os_tick;
  logic [DIV_W-1:0] div_max;
  logic maj;

  // Divider lookup
  // A new code takes effect at the next reload, so only the oversample period in flight keeps its length
  always_comb begin
    unique case (cfg.baud_select)
      3'h0: div_max = DIV_0;
      3'h1: div_max = DIV_1;
      3'h2: div_max = DIV_2;
      3'h3: div_max = DIV_3;
      3'h4: div_max = DIV_4;
      3'h5: div_max = DIV_5;
      3'h6: div_max = DIV_6;
      default: div_max = DIV_7;
    endcase
  end

  assign os_tick = (r.div_cnt == '0);
  // Majority of the three centre samples
  assign maj = (r.smp[0] & r.smp[1]) | (r.smp[1] & r.smp[2]) | (r.smp[0] & r.smp[2]);

  // Only the receive word goes through the FIFO; its error bits set the flags directly
  assign fifo_in_data = r.rx_shift;
  assign fifo_out_ready = !rx_full_q;

  // Next-state logic for both sections
  always_comb begin
    logic [3:0] nb;
    logic done_rx;
    nb = ast_nbits(cfg.mode);
    next_r = r;
    done_rx = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_par_bad = 1'b0;
    fifo_frm_bad = 1'b0;
    next_r.tx_irq = 1'b0;
    next_r.err_irq = 1'b0;
    next_r.rx_prev = rx_pin;
    // Baud divider, one pulse per oversample period
    // Reload one short of the count, as the zero state is a cycle of its own
    next_r.div_cnt = os_tick ? div_max - 1'b1 : r.div_cnt - 1'b1;
    // Transmit holding buffer; write loads it when free
    if (tx_write && !r.tx_full && cfg.tx_enable) begin
      next_r.tx_hold = tx_data_reg;
      next_r.tx_full = 1'b1;
    end
    // Transmitter sequencer
    if (os_tick) begin
      next_r.tx_tick = r.tx_tick + 1'b1;
      unique case (r.tx_st)
        AST_IDLE: begin
          next_r.tx_line = 1'b1;
          next_r.tx_tick = CNT_RST;
          if (r.tx_full && cfg.tx_enable) begin
            next_r.tx_shift = r.tx_hold;
            next_r.tx_par = ast_parity(r.tx_hold, cfg);
            next_r.tx_full = 1'b0;
            next_r.tx_line = 1'b0;
            next_r.tx_st = AST_START;
          end
        end
        AST_START: begin
          if (r.tx_tick == TICK_LAST) begin
            next_r.tx_line = r.tx_shift[0];
            next_r.tx_bit = CNT_RST;
            next_r.tx_st = AST_DATA;
          end
        end
        AST_DATA: begin
          if (r.tx_tick == TICK_LAST) begin
            next_r.tx_shift = {1'b0, r.tx_shift[8:1]};
            next_r.tx_bit = r.tx_bit + 1'b1;
            next_r.tx_line = r.tx_shift[1];
            if (r.tx_bit == nb - 1'b1) begin
              if (ast_par_on(cfg)) begin
                // Parity frozen at load; the holding buffer may hold the next word
                next_r.tx_line = r.tx_par;
                next_r.tx_st = AST_PAR;
              end else begin
                next_r.tx_line = 1'b1;
                next_r.tx_st = AST_STOP;
              end
            end
          end
        end
        AST_PAR: begin
          if (r.tx_tick == TICK_LAST) begin
            next_r.tx_line = 1'b1;
            next_r.tx_st = AST_STOP;
          end
        end
        AST_STOP: begin
          if (r.tx_tick == TICK_LAST) begin
            next_r.tx_st = AST_IDLE;
            next_r.tx_irq = tx_irq_en;
          end
        end
      endcase
    end
    // Receiver sequencer
    if (!cfg.rx_enable) begin
      next_r.rx_st = AST_IDLE;
    end else if (r.rx_st == AST_IDLE) begin
      // Falling edge of start bit resets timing
      if (r.rx_prev && !rx_pin) begin
        next_r.rx_st = AST_START;
        next_r.rx_tick = CNT_RST;
        next_r.rx_frame_bad = 1'b0;
        next_r.rx_shift = DATA_RST;
        next_r.rx_bit = CNT_RST;
      end
    end else if (os_tick) begin
      next_r.rx_tick = r.rx_tick + 1'b1;
      // Three samples around mid-bit; the majority filters a short glitch
      if (r.rx_tick == SAMPLE_A) next_r.smp[0] = rx_pin;
      if (r.rx_tick == SAMPLE_B) next_r.smp[1] = rx_pin;
      if (r.rx_tick == SAMPLE_C) next_r.smp[2] = rx_pin;
      if (r.rx_tick == TICK_LAST) begin
        unique case (r.rx_st)
          AST_START: begin
            // Two or three zeros accept the start bit
            if (maj) next_r.rx_st = AST_IDLE;
            else next_r.rx_st = AST_DATA;
          end
          AST_DATA: begin
            next_r.rx_shift[r.rx_bit] = maj;
            next_r.rx_bit = r.rx_bit + 1'b1;
            if (r.rx_bit == nb - 1'b1) begin
              next_r.rx_st = ast_par_on(cfg) ? AST_PAR : AST_STOP;
            end
          end
          AST_PAR: begin
            next_r.rx_par = maj;
            next_r.rx_st = AST_STOP;
          end
          AST_STOP: begin
            next_r.rx_st = AST_IDLE;
            done_rx = 1'b1;
            fifo_in_valid = 1'b1;
            fifo_frm_bad = !maj;
            fifo_par_bad = ast_par_on(cfg) &&
                           (ast_parity(r.rx_shift, cfg) != r.rx_par);
          end
          default: next_r.rx_st = AST_IDLE;
        endcase
      end
    end
    // A word that finds the FIFO full is lost and counts as overrun
    next_r.err_irq = done_rx && err_irq_en &&
                     (fifo_par_bad || fifo_frm_bad || !fifo_in_ready ||
                      (|err_q));
  end

  // Data path FIFO gives the receive side its double buffering
  ast_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  assign err_pulse = fifo_in_valid;

  // State register
  // Reset leaves both lines at mark so no false start edge follows
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.tx_line <= 1'b1;
      r.rx_prev <= 1'b1;
      r.tx_st <= AST_IDLE;
      r.rx_st <= AST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Receive data register, full flag and sticky error flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_data_q <= DATA_RST;
      rx_full_q <= 1'b0;
      err_q <= '0;
    end else begin
      // The FIFO pops only into an empty register, so no word is dropped here
      // Load from FIFO wins over a read in the same cycle
      if (fifo_out_valid && !rx_full_q) begin
        rx_data_q <= fifo_out_data;
        rx_full_q <= 1'b1;
      end else if (rx_read) begin
        rx_full_q <= 1'b0;
      end
      // Set wins over clear for each flag
      err_q.parity_error_flag <= (err_q.parity_error_flag &&
        !err_clear.parity_error_flag) || (err_pulse && fifo_par_bad);
      err_q.framing_error_flag <= (err_q.framing_error_flag &&
        !err_clear.framing_error_flag) || (err_pulse && fifo_frm_bad);
      err_q.overrun_error_flag <= (err_q.overrun_error_flag &&
        !err_clear.overrun_error_flag) || (err_pulse && !fifo_in_ready);
    end
  end

  assign tx_pin = r.tx_line;
  assign tx_buffer_flag = r.tx_full;
  assign tx_empty_irq = r.tx_irq;
  assign rx_data_reg = rx_data_q;
  assign rx_full_flag = rx_full_q;
  assign err_flags = err_q;
  assign rx_error_irq = r.err_irq;

  // Checks on the transmit and receive behaviour
  a_idle_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.tx_st == AST_IDLE && $past(r.tx_st) == AST_IDLE) |-> tx_pin)
    else $error("line not high while idle");
  a_start_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.tx_st == AST_START) |-> !tx_pin)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.tx_st == AST_STOP) |-> tx_pin)
    else $error("stop bit not high");
  a_tx_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.tx_st == AST_IDLE && !cfg.tx_enable) |=> r.tx_st == AST_IDLE)
    else $error("sent while disabled");
  a_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tx_write && !tx_buffer_flag && cfg.tx_enable) |=> tx_buffer_flag)
    else $error("write did not set buffer flag");
  a_irq_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_empty_irq |-> $past(r.tx_st) == AST_STOP)
    else $error("empty irq without stop");

  // Receive side: enable, full flag and the read that clears it
  a_rx_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.rx_enable |=> r.rx_st == AST_IDLE)
    else $error("receiving while disabled");
  a_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_read && rx_full_flag) |=> !rx_full_flag)
    else $error("read did not clear full");
  a_full_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fifo_out_valid && !rx_full_flag) |=> rx_full_flag)
    else $error("full flag not set");
  a_full_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_full_flag && !rx_read) |=> rx_full_flag)
    else $error("full flag dropped without read");

  // Error flags follow the checks made as a word leaves the shifter; set beats clear
  a_err_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (err_flags.parity_error_flag && !err_clear.parity_error_flag)
    |=> err_flags.parity_error_flag)
    else $error("parity flag dropped");
  a_par_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fifo_in_valid && fifo_par_bad) |=> err_flags.parity_error_flag)
    else $error("parity error not flagged");
  a_frm_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fifo_in_valid && fifo_frm_bad) |=> err_flags.framing_error_flag)
    else $error("framing error not flagged");
  a_ovr_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fifo_in_valid && !fifo_in_ready) |=> err_flags.overrun_error_flag)
    else $error("overrun not flagged");

  // The error interrupt repeats while any flag is left set, and only when enabled
  a_irq_again: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fifo_in_valid && err_irq_en && (|err_flags)) |=> rx_error_irq)
    else $error("error irq not raised again");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_error_irq |-> $past(err_irq_en))
    else $error("error irq while masked");

  // Main scenarios
  c_tx_frame: cover property (@(posedge clk_sys) r.tx_st == AST_STOP ##1 tx_empty_irq);
  c_rx_word: cover property (@(posedge clk_sys) fifo_in_valid);
  c_rx_err: cover property (@(posedge clk_sys) rx_error_irq);
  c_rx_lost: cover property (@(posedge clk_sys) fifo_in_valid && !fifo_in_ready);
  c_rx_read: cover property (@(posedge clk_sys) rx_read && rx_full_flag);
endmodule : ast_uart

//--- rtl/ast_pkg.sv
// Package for the asynchronous serial transceiver: modes, timing, carriers.
// Assumes a single 50 MHz system clock and no register bus.
package ast_pkg;
  // System clock rate in Hz
  localparam int unsigned SYS_CLK_HZ = 50000000;
  // Oversampling factor of the receive tick
  localparam int unsigned OVERSAMPLE = 16;
  // Centre samples taken at these oversample ticks within a bit
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] TICK_LAST = 4'hf;
  // Divider width for the oversample tick generator
  localparam int unsigned DIV_W = 16;
  // Baud rates in bit/s for each select code (table is configurable)
  localparam int unsigned BAUD_0 = 115200;
  localparam int unsigned BAUD_1 = 57600;
  localparam int unsigned BAUD_2 = 38400;
  localparam int unsigned BAUD_3 = 19200;
  localparam int unsigned BAUD_4 = 9600;
  localparam int unsigned BAUD_5 = 4800;
  localparam int unsigned BAUD_6 = 2400;
  localparam int unsigned BAUD_7 = 1200;
  // Oversample divider counts derived from the clock rate
  localparam logic [DIV_W-1:0] DIV_0 = DIV_W'(SYS_CLK_HZ / (BAUD_0 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_1 = DIV_W'(SYS_CLK_HZ / (BAUD_1 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_2 = DIV_W'(SYS_CLK_HZ / (BAUD_2 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_3 = DIV_W'(SYS_CLK_HZ / (BAUD_3 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_4 = DIV_W'(SYS_CLK_HZ / (BAUD_4 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_5 = DIV_W'(SYS_CLK_HZ / (BAUD_5 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_6 = DIV_W'(SYS_CLK_HZ / (BAUD_6 * OVERSAMPLE));
  localparam logic [DIV_W-1:0] DIV_7 = DIV_W'(SYS_CLK_HZ / (BAUD_7 * OVERSAMPLE));
  // Receive FIFO shape
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned FIFO_D = 4;
  // Reset values
  localparam logic [8:0] DATA_RST = 9'h000;
  localparam logic [3:0] CNT_RST = 4'h0;

  // Character modes: 7 data bits, 8 data bits, 9 data bits without parity
  typedef enum logic [1:0] {
    AST_MODE_NONE = 2'h0,
    AST_MODE_7 = 2'h1,
    AST_MODE_8 = 2'h2,
    AST_MODE_9 = 2'h3
  } ast_mode_t;

  // Configuration carried as one group
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    ast_mode_t mode;
    logic parity_en;
    logic parity_odd;
    logic [2:0] baud_select;
  } ast_cfg_t;

  // Error flags as one group
  typedef struct packed {
    logic parity_error_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
  } ast_err_t;

  // Data bits used by a mode
  function automatic logic [3:0] ast_nbits(input ast_mode_t m);
    unique case (m)
      AST_MODE_7: ast_nbits = 4'h7;
      AST_MODE_9: ast_nbits = 4'h9;
      default: ast_nbits = 4'h8;
    endcase
  endfunction : ast_nbits

  // Parity is used only when enabled and the mode allows it
  function automatic logic ast_par_on(input ast_cfg_t c);
    ast_par_on = c.parity_en && (c.mode == AST_MODE_7 || c.mode == AST_MODE_8);
  endfunction : ast_par_on

  // Parity bit for data masked to seven bits in mode 7, otherwise to eight bits
  function automatic logic ast_parity(input logic [8:0] d, input ast_cfg_t c);
    logic [8:0] m;
    m = (c.mode == AST_MODE_7) ? {2'h0, d[6:0]} : {1'h0, d[7:0]};
    ast_parity = (^m) ^ c.parity_odd;
  endfunction : ast_parity
endpackage : ast_pkg

//--- rtl/ast_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/10ps
module ast_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  // Storage words
  logic [WIDTH-1:0] mem [DEPTH];
  // Pointers carry one extra bit to tell full from empty
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  // Honest flags from pointer compare
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Pointer and storage update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : ast_fifo

//--- bench/ast_peer.sv
// Far-side serial device model: sends frames and captures frames.
// Assumes its tasks are entered at a falling edge of the clock.
`timescale 1ns/10ps
module ast_peer #(
  parameter int BIT_CYC = 432
) (
  input wire logic clk_sys,
  input wire logic tx_pin,
  output logic rx_pin
);
  // Line rests at mark between frames
  initial rx_pin = 1'h1;

  // Bits leave LSB first, one per bit time
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rx_pin = f[i];
      repeat (BIT_CYC) @(negedge clk_sys);
    end
    rx_pin = 1'h1;
  endtask : send

  // Low spike far too short to pass as a start bit
  task automatic spike(input int c);
    rx_pin = 1'h0;
    repeat (c) @(negedge clk_sys);
    rx_pin = 1'h1;
  endtask : spike

  // Sample each bit mid-cell; return at mid stop so a next start is not missed
  task automatic grab(output logic [11:0] f, input int n);
    f = '0;
    @(negedge tx_pin);
    repeat (BIT_CYC / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      f[i] = tx_pin;
      if (i < n - 1) repeat (BIT_CYC) @(negedge clk_sys);
    end
  endtask : grab
endmodule : ast_peer

//--- bench/ast_uart_tb.sv
// Self-checking bench for the serial transceiver with a peer model.
// Assumes baud code 0; the peer bit time is 16 divider periods.
`timescale 1ns/10ps
module ast_uart_tb
  import ast_pkg::*;
;
  localparam int BIT_CYC = 16 * int'(DIV_0); // Clocks per bit
  logic clk_sys, rst_n, tx_write, tx_irq_en, tx_buffer_flag, tx_empty_irq;
  logic tx_pin, rx_pin, err_irq_en, rx_read, rx_full_flag, rx_error_irq;
  logic [8:0] tx_data_reg, rx_data_reg;
  ast_cfg_t cfg;
  ast_err_t err_clear, err_flags;
  int bad_count = 0;
  int cmp_count = 0;
  int n_txi = 0; // Empty pulses seen
  int n_rxi = 0; // Error pulses seen

  ast_uart i_ast_uart (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
    .tx_data_reg(tx_data_reg), .tx_write(tx_write), .tx_irq_en(tx_irq_en),
    .tx_buffer_flag(tx_buffer_flag), .tx_empty_irq(tx_empty_irq), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .err_irq_en(err_irq_en), .err_clear(err_clear),
    .rx_data_reg(rx_data_reg), .rx_read(rx_read), .rx_full_flag(rx_full_flag),
    .err_flags(err_flags), .rx_error_irq(rx_error_irq));
  ast_peer #(.BIT_CYC(BIT_CYC)) i_ast_peer (.clk_sys(clk_sys), .tx_pin(tx_pin),
    .rx_pin(rx_pin));

  // 50 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Pulses are one cycle, so tally them rather than poll
  always @(posedge clk_sys) begin
    if (tx_empty_irq === 1'h1) n_txi++;
    if (rx_error_irq === 1'h1) n_rxi++;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %0t %s", $time, what);
      bad_count++;
    end
  endtask : chk

  // Expected frame: start, data LSB first, parity if on, stop
  function automatic logic [11:0] frame(input logic [8:0] d, input int nb, input int p,
                                        input logic odd);
    logic [11:0] f;
    logic pc;
    f = '0;
    pc = odd;
    for (int i = 0; i < nb; i++) begin
      f[i+1] = d[i];
      pc ^= d[i];
    end
    if (p != 0) f[nb+1] = pc;
    f[nb+1+p] = 1'h1;
    return f;
  endfunction : frame

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic write(input logic [8:0] d);
    tx_data_reg = d;
    tx_write = 1'h1;
    tick(1);
    tx_write = 1'h0;
  endtask : write

  // Read pulse, then let the next word settle in
  task automatic read();
    rx_read = 1'h1;
    tick(1);
    rx_read = 1'h0;
    tick(4);
  endtask : read

  // Bounded wait so a lost word cannot hang the run
  task automatic wait_full();
    for (int k = 0; k < 600 && rx_full_flag !== 1'h1; k++) tick(1);
    tick(4);
  endtask : wait_full

  task automatic t_tx();
    ast_mode_t md [4] = '{AST_MODE_7, AST_MODE_8, AST_MODE_8, AST_MODE_9};
    logic [8:0] dv [4] = '{9'h1d3, 9'h0a7, 9'h0c3, 9'h15a};
    logic [11:0] got;
    int nb;
    int p;
    int a;
    for (int i = 0; i < 4; i++) begin
      cfg.mode = md[i];
      cfg.parity_en = (i != 2);
      cfg.parity_odd = (i == 1);
      tx_irq_en = (i != 0); // First case masks the pulse
      nb = (i == 0) ? 7 : (i == 3) ? 9 : 8;
      p = (i < 2) ? 1 : 0; // Nine-bit mode never adds parity
      a = n_txi;
      write(dv[i]);
      chk(12'(tx_buffer_flag), 12'h1, "buffer flag");
      // The peer sends the same frame back so the receiver sees every mode too
      fork
        i_ast_peer.grab(got, nb + p + 2);
        i_ast_peer.send(frame(dv[i], nb, p, cfg.parity_odd), nb + p + 2);
      join
      chk(got, frame(dv[i], nb, p, cfg.parity_odd), "tx frame");
      tick(BIT_CYC);
      chk(12'(tx_pin), 12'h1, "mark after stop");
      chk(12'(n_txi - a), 12'(tx_irq_en), "empty pulse");
      chk(12'(rx_data_reg), 12'(dv[i] & (9'h1ff >> (9 - nb))), "rx mode word");
      chk(12'(err_flags), 12'h0, "rx mode flags");
      read();
    end
    $display("test tx done");
  endtask : t_tx

  task automatic t_duplex();
    logic [11:0] g1, g2;
    cfg.mode = AST_MODE_8;
    cfg.parity_en = 1'h1;
    cfg.parity_odd = 1'h0;
    fork
      i_ast_peer.send(frame(9'h0b6, 8, 1, 1'h0), 11);
      begin
        i_ast_peer.grab(g1, 11);
        i_ast_peer.grab(g2, 11);
      end
      begin
        write(9'h03c);
        for (int k = 0; k < 2000 && tx_buffer_flag !== 1'h0; k++) tick(1);
        write(9'h1e1);
      end
    join
    chk(g1, frame(9'h03c, 8, 1, 1'h0), "first word");
    chk(g2, frame(9'h0e1, 8, 1, 1'h0), "queued word");
    wait_full();
    chk(12'(rx_data_reg), 12'h0b6, "rx data");
    chk(12'(err_flags), 12'h0, "clean word");
    read();
    chk(12'(rx_full_flag), 12'h0, "read clears full");
    $display("test duplex done");
  endtask : t_duplex

  task automatic t_err();
    int a;
    a = n_rxi;
    i_ast_peer.send(frame(9'h05a, 8, 1, 1'h0) ^ 12'h200, 11);
    wait_full();
    chk(12'(err_flags), 12'h004, "parity flag");
    chk(12'(n_rxi - a), 12'h1, "error pulse");
    read();
    i_ast_peer.send(frame(9'h033, 8, 1, 1'h0), 11);
    wait_full();
    chk(12'(n_rxi - a), 12'h2, "pulse again");
    chk(12'(err_flags), 12'h004, "flag sticky");
    read();
    err_clear.parity_error_flag = 1'h1;
    tick(1);
    err_clear = '0;
    tick(1);
    chk(12'(err_flags), 12'h0, "flag cleared");
    i_ast_peer.send(frame(9'h081, 8, 1, 1'h0) & ~12'h400, 11);
    wait_full();
    chk(12'(err_flags), 12'h001, "framing flag");
    read();
    err_clear.framing_error_flag = 1'h1;
    tick(1);
    err_clear = '0;
    tick(1);
    $display("test errors done");
  endtask : t_err

  // Fill register and FIFO until a word is lost, then drain in order
  task automatic t_over();
    for (int i = 0; i < 6; i++) begin
      i_ast_peer.send(frame(9'(16 + i), 8, 1, 1'h0), 11);
      tick(BIT_CYC);
    end
    chk(12'(err_flags), 12'h002, "overrun flag");
    for (int i = 0; i < 5; i++) begin
      chk(12'(rx_data_reg), 12'(16 + i), "drain order");
      read();
    end
    chk(12'(rx_full_flag), 12'h0, "drained");
    err_clear.overrun_error_flag = 1'h1;
    tick(1);
    err_clear = '0;
    $display("test overrun done");
  endtask : t_over

  task automatic t_off();
    cfg.rx_enable = 1'h0;
    cfg.tx_enable = 1'h0;
    write(9'h055);
    chk(12'(tx_buffer_flag), 12'h0, "write refused");
    i_ast_peer.send(frame(9'h0ff, 8, 1, 1'h0), 11);
    tick(BIT_CYC);
    chk(12'(rx_full_flag), 12'h0, "rx disabled");
    chk(12'(tx_pin), 12'h1, "tx stays idle");
    cfg.rx_enable = 1'h1;
    cfg.tx_enable = 1'h1;
    i_ast_peer.spike(54);
    tick(2 * BIT_CYC);
    chk(12'({rx_full_flag, err_flags}), 12'h0, "spike ignored");
    $display("test disable done");
  endtask : t_off

  // Code 1 must stretch the start bit to sixteen of its own divider periods
  task automatic t_baud();
    int cnt;
    cfg.baud_select = 3'h1;
    write(9'h0ff);
    @(negedge tx_pin);
    tick(1);
    for (cnt = 0; tx_pin === 1'h0 && cnt < 2000; cnt++) tick(1);
    chk(12'(cnt), 12'(16 * int'(DIV_1)), "baud code 1 start");
    cfg.baud_select = 3'h0;
    tick(11 * BIT_CYC);
    chk(12'({tx_pin, tx_buffer_flag}), 12'h2, "baud frame ends");
    $display("test baud done");
  endtask : t_baud

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Main sequence; tests run near 87k cycles
  initial begin
    rst_n = 1'h0;
    cfg = '0;
    cfg.tx_enable = 1'h1;
    cfg.rx_enable = 1'h1;
    tx_data_reg = '0;
    tx_write = 1'h0;
    tx_irq_en = 1'h1;
    err_irq_en = 1'h1;
    err_clear = '0;
    rx_read = 1'h0;
    tick(16);
    rst_n = 1'h1;
    tick(2);
    chk(12'({tx_pin, tx_buffer_flag, rx_full_flag, err_flags}), 12'h020, "reset");
    t_tx();
    t_duplex();
    t_err();
    t_over();
    t_off();
    t_baud();
    end_sim();
  end

  // Watchdog at 100k cycles, a little beyond the expected run
  initial begin
    #(20 * 100000);
    bad_count++;
    $display("unexpected %0t watchdog expired", $time);
    end_sim();
  end
endmodule : ast_uart_tb
